// ---- urf_receiver.sv ----
// Contract
// R1: Words are 8 or 9 bits; in 9-bit mode the top bit goes to a status field.
// R2: Recovery runs at sixteen times baud; shift register advances once per bit.
// R3: Each bit level is the majority of three samples in its bit period.
// R4: The three samples are ticks 7, 8 and 9 of sixteen.
// R5: Serial data enters the shift register least significant bit first.
// R6: After the stop bit is sampled the word moves to the buffer if room.
// R7: The buffer is a four-word FIFO while a fifth word is assembled.
// R8: A fifth word arriving at a full FIFO is dropped and overrun set.
// R9: Software programs format and baud before setting receive enable.
// R10: Once enabled the receiver searches the input for a start bit.
// R11: Data-available is set while FIFO holds data; count register shows words.
// R12: Interrupt when FIFO reaches trigger level and receive interrupt enabled.
// R13: Trigger level is one to four words, one after reset.
// R14: Data-available clears only after status read then data read.
// R15: A break is a framing error; frame ends after data plus one stop.
// R16: Break frame sets available and framing, stores zeros, irq, idle.
// R17: After a break wait for a high level before hunting a start.
// R18: Idle reads zero from start detection to stop, one otherwise; the code keeps it zero after a false start until the next frame ends.
// R19: Overrun also raises the interrupt when receive interrupt enabled.
// R20: Overrun clears by status access followed by a data read.
// R21: The shift register is not reachable from software.
// R22: Exactly one stop bit is checked per frame.
// R23: A low stop bit sets framing error; the word is still stored.
// R24: With parity on, a mismatch with the selected parity sets parity error.
// R25: Noise sets its flag with data-available; data kept, no extra irq.
`timescale 1ns/1ps

module urf_receiver (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic serial_in_pin_in,
    input wire logic [urf_pkg::ADDR_W-1:0] addr_in,
    input wire logic [urf_pkg::DATA_W-1:0] wr_data_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    output logic [urf_pkg::DATA_W-1:0] rd_data_out,
    output logic rx_irq_out
);

    // ************************************************************
    // Declarations
    // ************************************************************
    urf_pkg::urf_cfg_type cfg_ff;
    urf_pkg::urf_flags_type flags_ff;
    urf_pkg::urf_state_type state_ff;
    logic [8:0] rx_shift_reg_ff;
    logic [3:0] bit_cnt_ff;
    logic noise_pend_ff;
    logic armed_ff;
    logic restart;
    logic bit_done;
    logic bit_val;
    logic bit_noise;
    logic frame_done;
    logic [8:0] word;
    logic par_bit;
    logic par_ones;
    logic par_expect;
    logic par_bad;
    logic push_ready;
    logic [8:0] head;
    logic [2:0] count;
    logic data_rd;
    logic stat_rd;
    logic clear_seq;
    logic [3:0] last_bit;

    // ************************************************************
    // Bit recovery and receive buffer
    // ************************************************************
    assign restart = (state_ff == urf_pkg::RX_HUNT) && cfg_ff.rx_enable_bit
        && !serial_in_pin_in;

    urf_bit_sampler u_sampler (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .baud_div_in(cfg_ff.baud_div),
        .restart_in(restart),
        .line_in(serial_in_pin_in),
        .bit_done_out(bit_done),
        .bit_val_out(bit_val),
        .noise_out(bit_noise)
    );

    assign data_rd = rd_en_in && (addr_in == urf_pkg::ADDR_DATA);
    assign stat_rd = rd_en_in && (addr_in == urf_pkg::ADDR_STATUS);
    assign clear_seq = ce_in && data_rd && armed_ff;

    urf_rx_fifo #(
        .WIDTH(9),
        .DEPTH(4),
        .PTR_W(2)
    ) u_fifo (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .push_valid_in(frame_done),
        .push_data_in(word),
        .push_ready_out(push_ready),
        .pop_in(data_rd),
        .pop_data_out(head),
        .count_out(count)
    );

    // ************************************************************
    // Word assembly and checks
    // ************************************************************
    assign frame_done = ce_in && bit_done && (state_ff == urf_pkg::RX_STOP);
    assign last_bit = cfg_ff.word_len_sel ? urf_pkg::BITS_NINE_LAST : urf_pkg::BITS_EIGHT_LAST;

    // An 8-bit word sits in the upper bits after eight shifts.
    assign word = cfg_ff.word_len_sel ? rx_shift_reg_ff
        : {1'b0, rx_shift_reg_ff[8:1]}; // see R1

    // The parity bit is the top bit of the word and covers the bits below it.
    assign par_bit = cfg_ff.word_len_sel ? word[8] : word[7];
    assign par_ones = cfg_ff.word_len_sel ? ^word[7:0] : ^word[6:0];

    always_comb begin // see R24
        case (urf_pkg::urf_par_type'(cfg_ff.parity_type_sel))
            urf_pkg::PAR_EVEN: par_expect = par_ones;
            urf_pkg::PAR_ODD: par_expect = !par_ones;
            urf_pkg::PAR_MARK: par_expect = 1'b1;
            urf_pkg::PAR_SPACE: par_expect = 1'b0;
            default: par_expect = 1'b0;
        endcase
    end

    assign par_bad = cfg_ff.parity_enable_bit && (par_bit != par_expect);

    // ************************************************************
    // Receive sequencer
    // ************************************************************
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state_ff <= urf_pkg::RX_HUNT;
            bit_cnt_ff <= 4'h0;
            rx_shift_reg_ff <= 9'h000;
        end else if (ce_in) begin
            if (!cfg_ff.rx_enable_bit) begin
                state_ff <= urf_pkg::RX_HUNT;
            end else begin
                case (state_ff)
                    urf_pkg::RX_HUNT: begin
                        if (restart) begin // see R10
                            state_ff <= urf_pkg::RX_START;
                        end
                    end
                    urf_pkg::RX_START: begin
                        if (bit_done) begin
                            state_ff <= bit_val ? urf_pkg::RX_HUNT : urf_pkg::RX_DATA;
                            bit_cnt_ff <= 4'h0;
                        end
                    end
                    urf_pkg::RX_DATA: begin
                        if (bit_done) begin
                            rx_shift_reg_ff <= {bit_val, rx_shift_reg_ff[8:1]}; // see R5 R2
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                            if (bit_cnt_ff == last_bit) begin // see R15
                                state_ff <= urf_pkg::RX_STOP;
                            end
                        end
                    end
                    urf_pkg::RX_STOP: begin
                        // One stop bit only; a low one means the line may be in break.
                        if (bit_done) begin // see R22
                            state_ff <= bit_val ? urf_pkg::RX_HUNT : urf_pkg::RX_WAIT_HIGH;
                        end
                    end
                    urf_pkg::RX_WAIT_HIGH: begin
                        if (bit_done && bit_val) begin // see R17
                            state_ff <= urf_pkg::RX_HUNT;
                        end
                    end
                    default: state_ff <= urf_pkg::RX_HUNT;
                endcase
            end
        end
    end

    // Noise seen on the start and data bits is held until the word is stored; stop-bit noise is not counted.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            noise_pend_ff <= 1'b0;
        end else if (ce_in) begin
            if (restart) begin
                noise_pend_ff <= 1'b0;
            end else if (bit_done && bit_noise) begin
                noise_pend_ff <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Status flags
    // ************************************************************
    // Status read arms the clear; the following data read consumes it.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            armed_ff <= 1'b0;
        end else if (ce_in) begin
            if (stat_rd) begin
                armed_ff <= 1'b1;
            end else if (data_rd) begin
                armed_ff <= 1'b0;
            end
        end
    end

    // A new frame setting a flag wins over a clear in the same cycle.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            flags_ff <= '0;
            flags_ff.rx_idle_flag <= 1'b1;
        end else if (ce_in) begin
            if (restart) begin // see R18
                flags_ff.rx_idle_flag <= 1'b0;
            end else if (frame_done) begin // see R16
                flags_ff.rx_idle_flag <= 1'b1;
            end
            if (frame_done && push_ready) begin // see R11 R6
                flags_ff.rx_data_avail_flag <= 1'b1;
            end else if (clear_seq && (count == 3'h1)) begin // see R14
                flags_ff.rx_data_avail_flag <= 1'b0;
            end
            if (frame_done && !bit_val) begin // see R23 R15
                flags_ff.framing_err_flag <= 1'b1;
            end else if (clear_seq) begin
                flags_ff.framing_err_flag <= 1'b0;
            end
            if (frame_done && par_bad) begin // see R24
                flags_ff.parity_err_flag <= 1'b1;
            end else if (clear_seq) begin
                flags_ff.parity_err_flag <= 1'b0;
            end
            if (frame_done && push_ready && noise_pend_ff) begin // see R25
                flags_ff.noise_flag <= 1'b1;
            end else if (clear_seq) begin
                flags_ff.noise_flag <= 1'b0;
            end
            if (frame_done && !push_ready) begin // see R8
                flags_ff.overrun_flag <= 1'b1;
            end else if (clear_seq) begin // see R20
                flags_ff.overrun_flag <= 1'b0;
            end
        end
    end

    // Noise has no source of its own here: it rides on the level request.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            rx_irq_out <= 1'b0;
        end else if (ce_in) begin
            rx_irq_out <= cfg_ff.rx_irq_enable && (({1'b0, cfg_ff.trig_lvl} < count)
                || flags_ff.overrun_flag); // see R12 R13 R19
        end
    end

    // ************************************************************
    // Register port
    // ************************************************************
    // Only configuration is writable; the shift register has no address.
    always_ff @(posedge clk_sys_in) begin // see R21
        if (rst_in) begin
            cfg_ff.rx_enable_bit <= urf_pkg::CTRL_RST[urf_pkg::CTRL_RX_EN];
            cfg_ff.word_len_sel <= urf_pkg::CTRL_RST[urf_pkg::CTRL_WORD_LEN];
            cfg_ff.parity_enable_bit <= urf_pkg::CTRL_RST[urf_pkg::CTRL_PAR_EN];
            cfg_ff.parity_type_sel <= urf_pkg::CTRL_RST[urf_pkg::CTRL_PAR_TYPE +: 2];
            cfg_ff.rx_irq_enable <= urf_pkg::CTRL_RST[urf_pkg::CTRL_IRQ_EN];
            cfg_ff.trig_lvl <= urf_pkg::TRIG_RST; // see R13
            cfg_ff.baud_div <= urf_pkg::BAUD_DIV_RST;
        end else if (ce_in && wr_en_in) begin
            case (addr_in)
                urf_pkg::ADDR_CTRL: begin
                    cfg_ff.rx_enable_bit <= wr_data_in[urf_pkg::CTRL_RX_EN];
                    cfg_ff.word_len_sel <= wr_data_in[urf_pkg::CTRL_WORD_LEN];
                    cfg_ff.parity_enable_bit <= wr_data_in[urf_pkg::CTRL_PAR_EN];
                    cfg_ff.parity_type_sel <= wr_data_in[urf_pkg::CTRL_PAR_TYPE +: 2];
                    cfg_ff.rx_irq_enable <= wr_data_in[urf_pkg::CTRL_IRQ_EN];
                end
                urf_pkg::ADDR_BAUD_LO: cfg_ff.baud_div[7:0] <= wr_data_in;
                urf_pkg::ADDR_BAUD_HI: cfg_ff.baud_div[15:8] <= wr_data_in;
                urf_pkg::ADDR_TRIG: cfg_ff.trig_lvl <= wr_data_in[1:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            rd_data_out <= 8'h00;
        end else if (ce_in) begin
            rd_data_out <= 8'h00;
            if (rd_en_in) begin
                case (addr_in)
                    urf_pkg::ADDR_CTRL: rd_data_out <= {2'h0, cfg_ff.rx_irq_enable,
                        cfg_ff.parity_type_sel, cfg_ff.parity_enable_bit,
                        cfg_ff.word_len_sel, cfg_ff.rx_enable_bit};
                    urf_pkg::ADDR_BAUD_LO: rd_data_out <= cfg_ff.baud_div[7:0];
                    urf_pkg::ADDR_BAUD_HI: rd_data_out <= cfg_ff.baud_div[15:8];
                    urf_pkg::ADDR_STATUS: rd_data_out <= {1'b0, head[8] && (count != 3'h0),
                        flags_ff.overrun_flag, flags_ff.noise_flag,
                        flags_ff.parity_err_flag, flags_ff.framing_err_flag,
                        flags_ff.rx_idle_flag, flags_ff.rx_data_avail_flag}; // see R1
                    urf_pkg::ADDR_DATA: rd_data_out <= (count != 3'h0) ? head[7:0] : 8'h00;
                    urf_pkg::ADDR_COUNT: rd_data_out <= {5'h00, count}; // see R11
                    urf_pkg::ADDR_TRIG: rd_data_out <= {6'h00, cfg_ff.trig_lvl};
                    default: rd_data_out <= 8'h00;
                endcase
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    AST_OVERRUN_SET: assert property (frame_done && !push_ready |=> flags_ff.overrun_flag
        && count == 3'h4 - {2'h0, $past(data_rd)}) // see R8
        else $error("Overrun not flagged or buffer changed.");
    AST_AVAIL_SET: assert property (frame_done && push_ready
        |=> flags_ff.rx_data_avail_flag && count != 3'h0) // see R11
        else $error("Stored word did not raise data available.");
    AST_AVAIL_HOLD: assert property (flags_ff.rx_data_avail_flag && !(clear_seq
        && count == 3'h1) |=> flags_ff.rx_data_avail_flag) // see R14
        else $error("Data available dropped without the clear sequence.");
    AST_IRQ_LEVEL: assert property (ce_in && cfg_ff.rx_irq_enable
        && ({1'b0, cfg_ff.trig_lvl} < count) |=> rx_irq_out) // see R12
        else $error("Trigger level reached without interrupt.");
    AST_IRQ_OVR: assert property (ce_in && cfg_ff.rx_irq_enable && flags_ff.overrun_flag
        |=> rx_irq_out) // see R19
        else $error("Overrun did not request an interrupt.");
    AST_IDLE_BUSY: assert property (state_ff == urf_pkg::RX_DATA
        |-> !flags_ff.rx_idle_flag) // see R18
        else $error("Idle flag high during a frame.");
    AST_BREAK_WAIT: assert property (ce_in && state_ff == urf_pkg::RX_WAIT_HIGH
        && cfg_ff.rx_enable_bit && !(bit_done && bit_val)
        |=> state_ff == urf_pkg::RX_WAIT_HIGH) // see R17
        else $error("Left break wait without a high level.");
    AST_FRAMING: assert property (frame_done && !bit_val |=> flags_ff.framing_err_flag
        && flags_ff.rx_idle_flag) // see R16 R23
        else $error("Low stop bit did not set framing error and idle.");
    AST_NINE_BIT: assert property (ce_in && cfg_ff.rx_enable_bit
        && state_ff == urf_pkg::RX_DATA && bit_done && bit_cnt_ff == last_bit
        |=> state_ff == urf_pkg::RX_STOP) // see R1 R15
        else $error("Frame length does not follow the word length select.");

endmodule : urf_receiver

// ---- urf_pkg.sv ----
package urf_pkg;

    // ************************************************************
    // Register map and bus widths
    // ************************************************************
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam logic [2:0] ADDR_CTRL = 3'h0;
    localparam logic [2:0] ADDR_BAUD_LO = 3'h1;
    localparam logic [2:0] ADDR_BAUD_HI = 3'h2;
    localparam logic [2:0] ADDR_STATUS = 3'h3;
    localparam logic [2:0] ADDR_DATA = 3'h4;
    localparam logic [2:0] ADDR_COUNT = 3'h5;
    localparam logic [2:0] ADDR_TRIG = 3'h6;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CTRL_RX_EN = 0;
    localparam int CTRL_WORD_LEN = 1;
    localparam int CTRL_PAR_EN = 2;
    localparam int CTRL_PAR_TYPE = 3;
    localparam int CTRL_IRQ_EN = 5;
    localparam int ST_AVAIL = 0;
    localparam int ST_IDLE = 1;
    localparam int ST_FERR = 2;
    localparam int ST_PERR = 3;
    localparam int ST_NOISE = 4;
    localparam int ST_OVR = 5;
    localparam int ST_NINTH = 6;

    // ************************************************************
    // Reset values and timing counts
    // ************************************************************
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] BAUD_DIV_RST = 16'h0000;
    localparam logic [1:0] TRIG_RST = 2'h0;
    localparam logic [3:0] OS_SAMPLE_A = 4'h7;
    localparam logic [3:0] OS_SAMPLE_B = 4'h8;
    localparam logic [3:0] OS_SAMPLE_C = 4'h9;
    localparam logic [3:0] BITS_NINE_LAST = 4'h8;
    localparam logic [3:0] BITS_EIGHT_LAST = 4'h7;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        PAR_EVEN = 2'h0,
        PAR_ODD = 2'h1,
        PAR_MARK = 2'h2,
        PAR_SPACE = 2'h3
    } urf_par_type;

    typedef enum logic [2:0] {
        RX_HUNT = 3'h0,
        RX_START = 3'h1,
        RX_DATA = 3'h2,
        RX_STOP = 3'h3,
        RX_WAIT_HIGH = 3'h4
    } urf_state_type;

    typedef struct packed {
        logic rx_enable_bit;
        logic word_len_sel;
        logic parity_enable_bit;
        logic [1:0] parity_type_sel;
        logic rx_irq_enable;
        logic [1:0] trig_lvl;
        logic [15:0] baud_div;
    } urf_cfg_type;

    typedef struct packed {
        logic rx_data_avail_flag;
        logic rx_idle_flag;
        logic framing_err_flag;
        logic parity_err_flag;
        logic noise_flag;
        logic overrun_flag;
    } urf_flags_type;

endpackage : urf_pkg

// ---- urf_bit_sampler.sv ----
`timescale 1ns/1ps

module urf_bit_sampler (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [15:0] baud_div_in,
    input wire logic restart_in,
    input wire logic line_in,
    output logic bit_done_out,
    output logic bit_val_out,
    output logic noise_out
);

    logic [15:0] pre_ff;
    logic [3:0] phase_ff;
    logic samp_a_ff;
    logic samp_b_ff;
    logic os_tick;

    assign os_tick = (pre_ff == baud_div_in);

    // Prescaler gives sixteen ticks per bit; phase restarts on each start edge.
    always_ff @(posedge clk_sys_in) begin // see R2
        if (rst_in || (ce_in && restart_in)) begin
            pre_ff <= 16'h0000;
            phase_ff <= 4'h0;
        end else if (ce_in) begin
            pre_ff <= os_tick ? 16'h0000 : pre_ff + 16'h0001;
            if (os_tick) begin
                phase_ff <= phase_ff + 4'h1;
            end
        end
    end

    // Vote over ticks seven, eight and nine, centred on the bit middle.
    always_ff @(posedge clk_sys_in) begin // see R3 R4
        if (rst_in) begin
            samp_a_ff <= 1'b1;
            samp_b_ff <= 1'b1;
            bit_done_out <= 1'b0;
            bit_val_out <= 1'b1;
            noise_out <= 1'b0;
        end else if (ce_in) begin
            bit_done_out <= 1'b0;
            if (os_tick && !restart_in) begin
                if (phase_ff == urf_pkg::OS_SAMPLE_A) begin
                    samp_a_ff <= line_in;
                end
                if (phase_ff == urf_pkg::OS_SAMPLE_B) begin
                    samp_b_ff <= line_in;
                end
                if (phase_ff == urf_pkg::OS_SAMPLE_C) begin
                    bit_done_out <= 1'b1;
                    bit_val_out <= (samp_a_ff & samp_b_ff) | (samp_a_ff & line_in)
                        | (samp_b_ff & line_in);
                    noise_out <= !((samp_a_ff == samp_b_ff) && (samp_b_ff == line_in));
                end
            end
        end
    end

    AST_DONE_AT_NINE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        bit_done_out |-> $past(phase_ff) == urf_pkg::OS_SAMPLE_C) // see R4
        else $error("Bit decision not taken at tick nine.");

endmodule : urf_bit_sampler

// ---- urf_rx_fifo.sv ----
`timescale 1ns/1ps

module urf_rx_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4,
    parameter int PTR_W = 2
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic push_valid_in,
    input wire logic [WIDTH-1:0] push_data_in,
    output logic push_ready_out,
    input wire logic pop_in,
    output logic [WIDTH-1:0] pop_data_out,
    output logic [PTR_W:0] count_out
);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PTR_W-1:0] wr_ptr_ff;
    logic [PTR_W-1:0] rd_ptr_ff;
    logic [PTR_W:0] count_ff;
    logic do_push;
    logic do_pop;

    assign push_ready_out = (count_ff != (PTR_W+1)'(DEPTH));
    assign do_push = ce_in && push_valid_in && push_ready_out;
    assign do_pop = ce_in && pop_in && (count_ff != '0);
    assign pop_data_out = mem_ff[rd_ptr_ff];
    assign count_out = count_ff;

    // A full buffer refuses the push, so its contents stay untouched.
    always_ff @(posedge clk_sys_in) begin // see R7 R8
        if (do_push) begin
            mem_ff[wr_ptr_ff] <= push_data_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_ff <= wr_ptr_ff + PTR_W'(1);
            end
            if (do_pop) begin
                rd_ptr_ff <= rd_ptr_ff + PTR_W'(1);
            end
            count_ff <= count_ff + (PTR_W+1)'(do_push) - (PTR_W+1)'(do_pop);
        end
    end

endmodule : urf_rx_fifo

// ---- urf_line_model.sv ----
`timescale 1ns/1ps

module urf_line_model #(
    parameter int BIT_CLKS = 16
) (
    input wire logic clk_sys_in,
    output logic line_out
);
    initial line_out = 1'h1;
    // A hold above one stretches the stop level, so a low stop makes a break.
    task automatic send(input logic [8:0] w, input int n, input logic stop_v, input int hold,
        input int g);
        logic v;
        for (int i = -1; i < n + hold; i++) begin
            v = (i < 0) ? 1'h0 : (i >= n) ? stop_v : w[i];
            line_out <= v;
            repeat (9) @(posedge clk_sys_in);
            // Flipping only the middle vote sample makes noise but keeps the bit.
            line_out <= (i == g) ? !v : v;
            @(posedge clk_sys_in);
            line_out <= v;
            repeat (BIT_CLKS - 10) @(posedge clk_sys_in);
        end
        line_out <= 1'h1;
        repeat (BIT_CLKS) @(posedge clk_sys_in);
    endtask : send
endmodule : urf_line_model

// ---- tb_top.sv ----
`timescale 1ns/1ps

module tb_top;
    logic clk_sys_in, rst_in, line, wr_en, rd_en, rd_pend, irq, ce;
    logic [2:0] addr;
    logic [7:0] wr_data, rd_data;
    logic [16:0] lfsr;
    logic [7:0] exp_q[$];
    logic [7:0] sent[5];
    int n_mismatch = 0;
    int tests_run = 0;
    urf_receiver dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce),
        .serial_in_pin_in(line), .addr_in(addr), .wr_data_in(wr_data), .wr_en_in(wr_en),
        .rd_en_in(rd_en), .rd_data_out(rd_data), .rx_irq_out(irq));
    urf_line_model tx_u (.clk_sys_in(clk_sys_in), .line_out(line));
    // ********
    // Helpers
    // ********
    function automatic logic [16:0] nxt_lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction : nxt_lfsr
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'h1;
        @(posedge clk_sys_in);
        wr_en <= 1'h0;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk_sys_in);
        addr <= a;
        rd_en <= 1'h1;
        @(posedge clk_sys_in);
        rd_en <= 1'h0;
    endtask : rd
    task automatic close_out;
        $display("checks=%0d mismatches=%0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    initial begin
        clk_sys_in = 1'h0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    // Read data stand only in the cycle after the strobe.
    always @(posedge clk_sys_in) begin
        if (rd_pend) check(rd_data, exp_q.pop_front());
        rd_pend <= rd_en;
    end
    initial begin
        repeat (5000) @(posedge clk_sys_in);
        n_mismatch++;
        close_out();
    end
    // ********
    // Scenarios
    // ********
    initial begin
        {rst_in, wr_en, rd_en, rd_pend, addr, wr_data} = {4'h8, 11'h000};
        lfsr = 17'h10660;
        ce = 1'h1;
        repeat (12) @(posedge clk_sys_in);
        rst_in <= 1'h0;
        rd(urf_pkg::ADDR_STATUS, 8'h02);
        rd(urf_pkg::ADDR_TRIG, 8'h00);
        rd(3'h7, 8'h00);
        ce <= 1'h0;
        wr(urf_pkg::ADDR_TRIG, 8'h02);
        ce <= 1'h1;
        rd(urf_pkg::ADDR_TRIG, 8'h00);
        wr(urf_pkg::ADDR_BAUD_LO, 8'h00);
        wr(urf_pkg::ADDR_BAUD_HI, 8'h00);
        wr(urf_pkg::ADDR_TRIG, 8'h03);
        wr(urf_pkg::ADDR_CTRL, 8'h21);
        for (int i = 0; i < 5; i++) begin
            lfsr = nxt_lfsr(lfsr);
            sent[i] = lfsr[7:0];
            tx_u.send({1'h0, lfsr[7:0]}, 8, 1'h1, 1, -2);
            if (i == 2) check({7'h00, irq}, 8'h00);
            if (i == 3) rd(urf_pkg::ADDR_COUNT, 8'h04);
            if (i == 3) check({7'h00, irq}, 8'h01);
        end
        check({7'h00, irq}, 8'h01);
        rd(urf_pkg::ADDR_STATUS, 8'h23);
        for (int i = 0; i < 4; i++) begin
            if (i == 3) rd(urf_pkg::ADDR_STATUS, 8'h03);
            rd(urf_pkg::ADDR_DATA, sent[i]);
        end
        rd(urf_pkg::ADDR_COUNT, 8'h00);
        rd(urf_pkg::ADDR_STATUS, 8'h02);
        check({7'h00, irq}, 8'h00);
        tx_u.send(9'h000, 8, 1'h0, 5, -2);
        rd(urf_pkg::ADDR_STATUS, 8'h07);
        rd(urf_pkg::ADDR_DATA, 8'h00);
        wr(urf_pkg::ADDR_CTRL, 8'h27);
        tx_u.send(9'h1A5, 9, 1'h1, 1, 2);
        rd(urf_pkg::ADDR_STATUS, 8'h5B);
        rd(urf_pkg::ADDR_DATA, 8'hA5);
        repeat (4) @(posedge clk_sys_in);
        close_out();
    end
endmodule : tb_top
